// >>> hdl/splr_map.svh
// register offsets, reset values and field layout of the peak level readout
// assumes inclusion by bare name from the package, the peak tracker and the top module
`ifndef SPLR_MAP_SVH
`define SPLR_MAP_SVH
`define SPLR_ADDR_W 8
`define SPLR_DATA_W 8
`define SPLR_PEAK_W 16
`define SPLR_OFF_SEND_IN_LOW 8'h36
`define SPLR_OFF_SEND_IN_HIGH 8'h37
`define SPLR_OFF_RECV_OUT_LOW 8'h3A
`define SPLR_OFF_RECV_OUT_HIGH 8'h3B
`define SPLR_PEAK_RESET 16'h0000
`define SPLR_RDATA_RESET 8'h00
`define SPLR_LOW_LSB 0
`define SPLR_HIGH_LSB 8
`define SPLR_SAMPLE_ENA_TIME_NS 125000
`define SPLR_CLK_PERIOD_NS 10
`endif

// >>> hdl/splr_pkg.sv
// types shared by the peak level readout
// assumes splr_map.svh on the include path
`include "splr_map.svh"
package splr_pkg;
   typedef logic [`SPLR_PEAK_W-1:0] splr_peak_t;
   typedef logic [`SPLR_DATA_W-1:0] splr_byte_t;
   typedef logic [`SPLR_ADDR_W-1:0] splr_addr_t;
   typedef enum logic [1:0] {
      SPLR_SEL_NONE = 2'b00,
      SPLR_SEL_LOW = 2'b01,
      SPLR_SEL_HIGH = 2'b10
   } splr_sel_e;
endpackage : splr_pkg

// >>> hdl/splr_peak_track.sv
// one signed peak tracker: holds the largest magnitude sample seen
// assumes samples arrive with a one-cycle valid strobe, synchronous to clk
`timescale 1ns/100ps
`include "splr_map.svh"
module splr_peak_track (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // sample stream
   input wire logic sample_valid,
   input wire splr_pkg::splr_peak_t sample,
   // held peak
   output splr_pkg::splr_peak_t peak
);
   splr_pkg::splr_peak_t peak_q;
   splr_pkg::splr_peak_t peak_d;

   function automatic logic [15:0] splr_mag(input logic [15:0] v);
      splr_mag = v[15] ? 16'(~v + 16'h0001) : v;
   endfunction : splr_mag

   always_comb begin
      peak_d = peak_q;
      if (sample_valid && (splr_mag(sample) > splr_mag(peak_q))) begin
         peak_d = sample;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         peak_q <= `SPLR_PEAK_RESET;
      end else begin
         peak_q <= peak_d;
      end
   end

   assign peak = peak_q;
endmodule : splr_peak_track

// >>> hdl/splr_readout.sv
// What this block does
// - receive-path output peak is measured at its reference point, readable by software
// - send-path input peak is measured at its reference point, readable by software
// - each peak is a 16-bit two's complement linear value
// - peak split in two byte registers: low byte first, high byte second
// - address 3Ah reads receive-output low byte, 3Bh its high byte
// - address 36h reads send-input low byte, 37h its high byte
//
// top of the peak level readout: two trackers and a read-only register port
// assumes a single 100 MHz clock and samples already in linear form
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "splr_map.svh"
module splr_readout (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // receive output reference point stream
   input wire logic receive_output_ref_point_valid,
   input wire splr_pkg::splr_peak_t receive_output_ref_point,
   // send input reference point stream
   input wire logic send_input_ref_point_valid,
   input wire splr_pkg::splr_peak_t send_input_ref_point,
   // register port
   input wire splr_pkg::splr_addr_t reg_addr,
   input wire splr_pkg::splr_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output splr_pkg::splr_byte_t reg_rdata
);
   splr_pkg::splr_peak_t receive_output_peak_bits;
   splr_pkg::splr_peak_t send_input_peak_bits;
   splr_pkg::splr_byte_t rdata_q;
   splr_pkg::splr_byte_t rdata_d;

   // ****************************************
   // peak trackers
   // ****************************************
   splr_peak_track u_recv_out (
      .clk(clk),
      .rst_n(rst_n),
      .sample_valid(receive_output_ref_point_valid),
      .sample(receive_output_ref_point),
      .peak(receive_output_peak_bits)
   );

   splr_peak_track u_send_in (
      .clk(clk),
      .rst_n(rst_n),
      .sample_valid(send_input_ref_point_valid),
      .sample(send_input_ref_point),
      .peak(send_input_peak_bits)
   );

   // ****************************************
   // register read
   // ****************************************
   function automatic splr_pkg::splr_byte_t splr_half(input splr_pkg::splr_peak_t v,
                                                      input logic high);
      splr_half = high ? v[`SPLR_HIGH_LSB +: 8] : v[`SPLR_LOW_LSB +: 8];
   endfunction : splr_half

   // write data and write strobe are ignored: every register is read-only
   always_comb begin
      rdata_d = `SPLR_RDATA_RESET;
      if (reg_rd) begin
         case (reg_addr)
            `SPLR_OFF_RECV_OUT_LOW: rdata_d = splr_half(receive_output_peak_bits, 1'b0);
            `SPLR_OFF_RECV_OUT_HIGH: rdata_d = splr_half(receive_output_peak_bits, 1'b1);
            `SPLR_OFF_SEND_IN_LOW: rdata_d = splr_half(send_input_peak_bits, 1'b0);
            `SPLR_OFF_SEND_IN_HIGH: rdata_d = splr_half(send_input_peak_bits, 1'b1);
            default: rdata_d = `SPLR_RDATA_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= `SPLR_RDATA_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ****************************************
   // checks
   // ****************************************
   // magnitude of a signed sample; the most negative value gives 16'h8000
   function automatic logic [15:0] splr_abs(input splr_pkg::splr_peak_t v);
      splr_abs = v[15] ? 16'(~v + 16'h0001) : v;
   endfunction : splr_abs

   function automatic logic splr_mapped(input splr_pkg::splr_addr_t a);
      splr_mapped = (a == `SPLR_OFF_RECV_OUT_LOW) || (a == `SPLR_OFF_RECV_OUT_HIGH)
                    || (a == `SPLR_OFF_SEND_IN_LOW) || (a == `SPLR_OFF_SEND_IN_HIGH);
   endfunction : splr_mapped

   // ****************************************
   // read port checks
   // ****************************************
   chk_recv_low_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && (reg_addr == `SPLR_OFF_RECV_OUT_LOW)
      |=> (reg_rdata == $past(receive_output_peak_bits[`SPLR_LOW_LSB +: 8])))
      else $error("receive low byte mismatch");

   chk_recv_high_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && (reg_addr == `SPLR_OFF_RECV_OUT_HIGH)
      |=> (reg_rdata == $past(receive_output_peak_bits[`SPLR_HIGH_LSB +: 8])))
      else $error("receive high byte mismatch");

   chk_send_low_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && (reg_addr == `SPLR_OFF_SEND_IN_LOW)
      |=> (reg_rdata == $past(send_input_peak_bits[`SPLR_LOW_LSB +: 8])))
      else $error("send low byte mismatch");

   chk_send_high_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && (reg_addr == `SPLR_OFF_SEND_IN_HIGH)
      |=> (reg_rdata == $past(send_input_peak_bits[`SPLR_HIGH_LSB +: 8])))
      else $error("send high byte mismatch");

   chk_recv_high_sign: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && (reg_addr == `SPLR_OFF_RECV_OUT_HIGH)
      |=> (reg_rdata[7] == $past(receive_output_peak_bits[`SPLR_PEAK_W-1])))
      else $error("receive sign bit not in high byte");

   chk_send_high_sign: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && (reg_addr == `SPLR_OFF_SEND_IN_HIGH)
      |=> (reg_rdata[7] == $past(send_input_peak_bits[`SPLR_PEAK_W-1])))
      else $error("send sign bit not in high byte");

   chk_idle_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      !reg_rd |=> (reg_rdata == `SPLR_RDATA_RESET))
      else $error("read data without read strobe");

   chk_unmapped_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && !splr_mapped(reg_addr) |=> (reg_rdata == `SPLR_RDATA_RESET))
      else $error("unmapped read gave data");

   chk_write_ignored: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && !receive_output_ref_point_valid && !send_input_ref_point_valid
      |=> $stable(receive_output_peak_bits) && $stable(send_input_peak_bits))
      else $error("write changed a peak");

   chk_read_no_effect: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && !receive_output_ref_point_valid && !send_input_ref_point_valid
      ##1 reg_rd && $stable(reg_addr)
      |=> $stable(reg_rdata))
      else $error("repeated read gave another value");

   // ****************************************
   // tracker checks
   // ****************************************
   chk_recv_peak_tracks: assert property (
      @(posedge clk) disable iff (!rst_n)
      receive_output_ref_point_valid && (receive_output_ref_point == 16'h7FFF)
      && (splr_abs(receive_output_peak_bits) < 16'h7FFF)
      |=> (receive_output_peak_bits == 16'h7FFF))
      else $error("receive peak missed full scale");

   chk_send_peak_tracks: assert property (
      @(posedge clk) disable iff (!rst_n)
      send_input_ref_point_valid && (send_input_ref_point == 16'h7FFF)
      && (splr_abs(send_input_peak_bits) < 16'h7FFF)
      |=> (send_input_peak_bits == 16'h7FFF))
      else $error("send peak missed full scale");

   chk_neg_peak_kept: assert property (
      @(posedge clk) disable iff (!rst_n)
      send_input_ref_point_valid && (send_input_ref_point == 16'h8001)
      && (splr_abs(send_input_peak_bits) < 16'h7FFF)
      |=> send_input_peak_bits[15])
      else $error("negative peak lost sign");

   chk_recv_peak_rise: assert property (
      @(posedge clk) disable iff (!rst_n)
      receive_output_ref_point_valid
      && (splr_abs(receive_output_ref_point) > splr_abs(receive_output_peak_bits))
      |=> (receive_output_peak_bits == $past(receive_output_ref_point)))
      else $error("receive peak not replaced by larger sample");

   chk_send_peak_rise: assert property (
      @(posedge clk) disable iff (!rst_n)
      send_input_ref_point_valid
      && (splr_abs(send_input_ref_point) > splr_abs(send_input_peak_bits))
      |=> (send_input_peak_bits == $past(send_input_ref_point)))
      else $error("send peak not replaced by larger sample");

   chk_recv_peak_keep: assert property (
      @(posedge clk) disable iff (!rst_n)
      receive_output_ref_point_valid
      && (splr_abs(receive_output_ref_point) <= splr_abs(receive_output_peak_bits))
      |=> $stable(receive_output_peak_bits))
      else $error("receive peak replaced by smaller sample");

   chk_send_peak_keep: assert property (
      @(posedge clk) disable iff (!rst_n)
      send_input_ref_point_valid
      && (splr_abs(send_input_ref_point) <= splr_abs(send_input_peak_bits))
      |=> $stable(send_input_peak_bits))
      else $error("send peak replaced by smaller sample");

   chk_recv_peak_mono: assert property (
      @(posedge clk) disable iff (!rst_n)
      1'b1
      |=> (splr_abs(receive_output_peak_bits) >= $past(splr_abs(receive_output_peak_bits))))
      else $error("receive peak magnitude fell");

   chk_send_peak_mono: assert property (
      @(posedge clk) disable iff (!rst_n)
      1'b1
      |=> (splr_abs(send_input_peak_bits) >= $past(splr_abs(send_input_peak_bits))))
      else $error("send peak magnitude fell");

   chk_peak_held: assert property (
      @(posedge clk) disable iff (!rst_n)
      !receive_output_ref_point_valid && !send_input_ref_point_valid
      |=> $stable(receive_output_peak_bits) && $stable(send_input_peak_bits))
      else $error("peak moved without a sample");
endmodule : splr_readout

// >>> tb/splr_readout_bench.sv
// bench for the peak level readout: reset values, peak tracking, read-only map
// assumes splr_pkg and splr_readout compiled first, splr_map.svh on the include path
`timescale 1ns/100ps
module splr_readout_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic recv_valid = 1'b0;
   logic send_valid = 1'b0;
   splr_pkg::splr_peak_t recv_sample = 16'h0000;
   splr_pkg::splr_peak_t send_sample = 16'h0000;
   splr_pkg::splr_addr_t reg_addr = 8'h00;
   splr_pkg::splr_byte_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   splr_pkg::splr_byte_t reg_rdata;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   splr_pkg::splr_addr_t offs [4] = '{8'h36, 8'h37, 8'h3A, 8'h3B};
   always #5 clk = ~clk;
   splr_readout u_dut (.clk(clk), .rst_n(rst_n),
      .receive_output_ref_point_valid(recv_valid), .receive_output_ref_point(recv_sample),
      .send_input_ref_point_valid(send_valid), .send_input_ref_point(send_sample),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic check(input splr_pkg::splr_byte_t got, input splr_pkg::splr_byte_t exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t read 0x%h, expected 0x%h", $time, got, exp);
      end
   endtask : check
   // one read; data stands in the next cycle only
   task automatic rd(input splr_pkg::splr_addr_t a, input splr_pkg::splr_byte_t exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
      @(posedge clk);
      #1 check(reg_rdata, 8'h00);
   endtask : rd
   // two reads back to back; each byte stands one cycle
   task automatic rd2(input splr_pkg::splr_addr_t a, input splr_pkg::splr_addr_t b,
                      input splr_pkg::splr_byte_t exp_a, input splr_pkg::splr_byte_t exp_b);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_addr <= b;
      #1 check(reg_rdata, exp_a);
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp_b);
      @(posedge clk);
      #1 check(reg_rdata, 8'h00);
   endtask : rd2
   task automatic wr(input splr_pkg::splr_addr_t a, input splr_pkg::splr_byte_t d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // one sample strobe on the send (snd=1) or receive stream
   task automatic push(input logic snd, input splr_pkg::splr_peak_t v);
      @(posedge clk);
      if (snd) begin
         send_valid <= 1'b1;
         send_sample <= v;
      end else begin
         recv_valid <= 1'b1;
         recv_sample <= v;
      end
      @(posedge clk);
      send_valid <= 1'b0;
      recv_valid <= 1'b0;
   endtask : push
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      foreach (offs[i]) rd(offs[i], 8'h00);
      $display("reset values done");
      push(1'b0, 16'h1234);
      rd(8'h3A, 8'h34);
      rd(8'h3B, 8'h12);
      push(1'b0, 16'hE000);
      push(1'b0, 16'h0100);
      push(1'b1, 16'h7FFF);
      push(1'b1, 16'h8000);
      push(1'b1, 16'h8001);
      rd(8'h3A, 8'h00);
      rd(8'h3B, 8'hE0);
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h80);
      $display("peak tracking done");
      foreach (offs[i]) wr(offs[i], 8'hFF);
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h80);
      rd(8'h3A, 8'h00);
      rd(8'h3B, 8'hE0);
      rd(8'h3B, 8'hE0);
      rd(8'h38, 8'h00);
      $display("read-only map done");
      rd2(8'h3B, 8'h3B, 8'hE0, 8'hE0);
      rd2(8'h36, 8'h3A, 8'h00, 8'h00);
      $display("back to back reads done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      foreach (offs[i]) rd(offs[i], 8'h00);
      push(1'b1, 16'h0100);
      push(1'b1, 16'hFF00);
      rd2(8'h37, 8'h36, 8'h01, 8'h00);
      push(1'b0, 16'h8000);
      rd2(8'h3B, 8'h3A, 8'h80, 8'h00);
      $display("mid-run reset done");
      end_of_test();
   end
endmodule : splr_readout_bench
